// ### rtl/drsfc_top.sv
// Sleep-state decode, rail switching, fault latches and power-ok for the dual-rail controller
`timescale 1ns/1ns
// Function
// - S5 on supply low or rail enable low; S0 both high; S3 otherwise; S5 gates low
// - S0 switches complementary gates at 300 kHz
// - S3 switches at 600 kHz
// - S3 keeps low-side gate low, only high-side switches
// - Dead time keeps both gates from being high together
// - Leaving S5 always restarts the memory rail through soft-start
// - Memory rail in-regulation flag raised once rail regulates
// - Termination rail on only in S0 with memory rail in regulation
// - Termination in-regulation flag raised in S0 once it regulates
// - Termination output high impedance in S3 and S5
// - Termination runs constant current at its limit until regulating
// - Overcurrent sampled only with high-side on, after 500 ns blanking
// - Overcurrent latches all outputs off, power-ok low
// - Fault latch clears only by cycling supply or rail enable
// - Supply-good flag with hysteresis; low forces S5
// - Overtemperature shuts everything off until supply or enable cycles
// - Power-ok released only in S0 with both rails good, else low
// - Memory rail over 130, or under 65 percent once soft-start ends, flags a fault
module drsfc_top import drsfc_pkg::*; (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire drsfc_sense_s sense_i,
	input wire drsfc_wb_req_s wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic high_side_gate_o,
	output logic low_side_gate_o,
	output logic memory_rail_hiz_o,
	output logic termination_on_o,
	output logic termination_hiz_o,
	output logic termination_cc_o,
	output logic power_ok_out_o,
	output logic power_ok_out_oe_o,
	output logic supply_good_flag_o,
	output logic memory_rail_in_regulation_o,
	output logic termination_in_regulation_o
);
	// ---------------------------------------------------------------
	// Reset release and input resampling
	// ---------------------------------------------------------------
	logic rst_a_r, rst_n;
	drsfc_sense_s s1_r, s_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_a_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_n <= rst_a_r;
		end
	end

	// Pins are asynchronous to the oscillator; only s_r is read below
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s_r <= '0;
		end else begin
			s1_r <= sense_i;
			s_r <= s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Supply monitor and state decode
	// ---------------------------------------------------------------
	logic sgood_r;
	drsfc_state_e st_r, st_nxt;
	logic oc_r, ot_r, rf_r, fault_any, fault_clr;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sgood_r <= 1'b0;
		end else if (s_r.sup_above_rise) begin
			sgood_r <= 1'b1;
		end else if (!s_r.sup_above_fall) begin
			sgood_r <= 1'b0;
		end
	end

	always_comb begin
		if (!sgood_r || !s_r.mem_en) begin
			st_nxt = ST_S5;
		end else if (s_r.term_en) begin
			st_nxt = ST_S0;
		end else begin
			st_nxt = ST_S3;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_S5;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	logic [5:0] duty_tgt_r;
	logic [7:0] ss_step_r;
	logic ack_r, wb_hit;
	assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_r;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			duty_tgt_r <= DUTY_RST;
			ss_step_r <= SS_STEP_RST;
		end else if (wb_hit && wb_req_i.we && wb_req_i.adr == ADR_CTRL) begin
			if (wb_req_i.sel[0]) begin
				duty_tgt_r <= wb_req_i.dat[5:0];
			end
			if (wb_req_i.sel[1]) begin
				ss_step_r <= wb_req_i.dat[15:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// Soft-start ramp
	// ---------------------------------------------------------------
	logic [5:0] ss_lim_r;
	logic [7:0] ss_cnt_r;
	logic ss_done;
	assign ss_done = ss_lim_r >= duty_tgt_r;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ss_lim_r <= '0;
			ss_cnt_r <= '0;
		end else if (st_r == ST_S5 || fault_any) begin
			ss_lim_r <= '0;
			ss_cnt_r <= '0;
		end else if (!ss_done) begin
			if (ss_cnt_r >= ss_step_r) begin
				ss_cnt_r <= '0;
				ss_lim_r <= ss_lim_r + 6'h01;
			end else begin
				ss_cnt_r <= ss_cnt_r + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Modulator and gate drive
	// ---------------------------------------------------------------
	// Duty is the smallest of target, ramp and the 90 percent ceiling
	function automatic logic [5:0] duty_pick(input logic [5:0] a, b, c);
		logic [5:0] m;
		m = (a < b) ? a : b;
		return (m < c) ? m : c;
	endfunction : duty_pick

	logic [5:0] cnt_r, per, duty_eff;
	logic run, hs_r, ls_r, hs_want, ls_want;
	logic [2:0] blank_r;
	assign run = (st_r != ST_S5) && !fault_any;
	assign per = (st_r == ST_S3) ? PER_S3 : PER_S0;
	assign duty_eff = duty_pick(duty_tgt_r, ss_lim_r, (st_r == ST_S3) ? MAXD_S3 : MAXD_S0);
	assign hs_want = run && (cnt_r < duty_eff);
	assign ls_want = run && (st_r == ST_S0) && (cnt_r >= 6'(duty_eff + DEAD_CYC))
		&& (cnt_r < 6'(per - DEAD_CYC));

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (!run || cnt_r >= 6'(per - 6'h01)) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 6'h01;
		end
	end

	// Each gate waits for the other to be seen low, so an edge never overlaps
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hs_r <= 1'b0;
			ls_r <= 1'b0;
		end else begin
			hs_r <= hs_want && !ls_r;
			ls_r <= ls_want && !hs_want && !hs_r;
		end
	end

	// ---------------------------------------------------------------
	// Fault latches
	// ---------------------------------------------------------------
	logic oc_take, rf_take;
	assign oc_take = (st_r != ST_S5) && hs_r && blank_r == BLANK_CYC && s_r.overcurrent;
	assign rf_take = run && (s_r.mem_fb_over || (ss_done && s_r.mem_fb_under));
	assign fault_any = oc_r || ot_r || rf_r;
	assign fault_clr = !sgood_r || !s_r.mem_en;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			blank_r <= '0;
		end else if (!hs_r) begin
			blank_r <= '0;
		end else if (blank_r != BLANK_CYC) begin
			blank_r <= blank_r + 3'h1;
		end
	end

	// A new event wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			oc_r <= 1'b0;
			ot_r <= 1'b0;
			rf_r <= 1'b0;
		end else begin
			oc_r <= oc_take || (oc_r && !fault_clr);
			ot_r <= s_r.overtemp || (ot_r && !fault_clr);
			rf_r <= rf_take || (rf_r && !fault_clr);
		end
	end

	// ---------------------------------------------------------------
	// Rail flags, termination and power-ok
	// ---------------------------------------------------------------
	logic mem_inreg_r, term_on_r, term_inreg_r, pok_oe_r, term_hiz_r, term_cc_r;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_inreg_r <= 1'b0;
			term_on_r <= 1'b0;
			term_inreg_r <= 1'b0;
			pok_oe_r <= 1'b1;
			term_hiz_r <= 1'b1;
			term_cc_r <= 1'b0;
		end else begin
			mem_inreg_r <= run && ss_done && s_r.mem_fb_ok;
			term_on_r <= (st_r == ST_S0) && mem_inreg_r && !fault_any;
			term_inreg_r <= (st_r == ST_S0) && term_on_r && s_r.term_fb_ok;
			term_hiz_r <= !((st_r == ST_S0) && mem_inreg_r && !fault_any);
			term_cc_r <= (st_r == ST_S0) && mem_inreg_r && !fault_any
				&& !(term_on_r && s_r.term_fb_ok);
			pok_oe_r <= !((st_r == ST_S0) && mem_inreg_r && term_inreg_r
				&& !fault_any);
		end
	end

	assign high_side_gate_o = hs_r;
	assign low_side_gate_o = ls_r;
	assign termination_on_o = term_on_r;
	assign termination_cc_o = term_cc_r;
	assign termination_hiz_o = term_hiz_r;
	assign memory_rail_hiz_o = !mem_inreg_r && !hs_r && !ls_r;
	assign power_ok_out_o = 1'b0;
	assign power_ok_out_oe_o = pok_oe_r;
	assign supply_good_flag_o = sgood_r;
	assign memory_rail_in_regulation_o = mem_inreg_r;
	assign termination_in_regulation_o = term_inreg_r;

	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	drsfc_stat_s stat;
	logic [31:0] rd_r;
	assign stat = '{state: st_r, supply_good: sgood_r, mem_inreg: mem_inreg_r,
		term_inreg: term_inreg_r, soft_start: !ss_done, oc_latch: oc_r,
		ot_latch: ot_r, rail_fault: rf_r};

	// Unmapped addresses still acknowledge and read zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			rd_r <= '0;
		end else begin
			ack_r <= wb_hit;
			if (wb_req_i.adr == ADR_CTRL) begin
				rd_r <= {16'h0000, ss_step_r, 2'h0, duty_tgt_r};
			end else if (wb_req_i.adr == ADR_STAT) begin
				rd_r <= {22'h0, stat};
			end else begin
				rd_r <= '0;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rd_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	property p_s5_off;
		(st_r == ST_S5) |=> !hs_r && !ls_r;
	endproperty
	a_s5_off: assert property (p_s5_off) else $error("gate high in S5");
	property p_no_overlap;
		!(hs_r && ls_r);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
	property p_s3_low;
		(st_r == ST_S3) |=> !ls_r;
	endproperty
	a_s3_low: assert property (p_s3_low) else $error("low gate in S3");
	property p_blank;
		$rose(hs_r) |-> !oc_take [*5];
	endproperty
	a_blank: assert property (p_blank) else $error("overcurrent sampled in blanking");
	property p_oc_off;
		oc_take |=> oc_r ##1 (!hs_r && !ls_r && !term_on_r && pok_oe_r);
	endproperty
	a_oc_off: assert property (p_oc_off) else $error("overcurrent not latched off");
	property p_oc_hold;
		oc_r && !fault_clr |=> oc_r;
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("latch cleared without cycle");
	property p_ss_restart;
		(st_r == ST_S5) ##1 (st_r != ST_S5) |-> ss_lim_r == 6'h00;
	endproperty
	a_ss_restart: assert property (p_ss_restart) else $error("no soft-start");
	property p_term_gate;
		term_on_r |-> $past(st_r == ST_S0 && mem_inreg_r);
	endproperty
	a_term_gate: assert property (p_term_gate) else $error("termination on wrongly");
	property p_pok;
		!pok_oe_r |-> $past(st_r == ST_S0 && term_inreg_r && !fault_any);
	endproperty
	a_pok: assert property (p_pok) else $error("power-ok released wrongly");
	c_s0_ok: cover property (st_r == ST_S0 ##[1:200] !pok_oe_r);
	c_oc: cover property ($rose(oc_r));
	c_s3_sw: cover property (st_r == ST_S3 && $rose(hs_r));
	c_recover: cover property (oc_r ##[1:50] !oc_r);
endmodule : drsfc_top

// ### rtl/drsfc_pkg.sv
// Shared constants, types and register layout of the rail state and fault controller
package drsfc_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_MHZ = 10;
	localparam int F_S0_HZ = 300_000;
	localparam int F_S3_HZ = 600_000;
	localparam int BLANK_NS = 500;
	localparam logic [5:0] PER_S0 = 6'(CLK_HZ / F_S0_HZ);
	localparam logic [5:0] PER_S3 = 6'(CLK_HZ / F_S3_HZ);
	localparam logic [2:0] BLANK_CYC = 3'((BLANK_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] DEAD_CYC = 6'h01;
	localparam logic [5:0] MAXD_S0 = 6'((CLK_HZ / F_S0_HZ) * 9 / 10);
	localparam logic [5:0] MAXD_S3 = 6'((CLK_HZ / F_S3_HZ) * 9 / 10);
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [5:0] DUTY_RST = 6'h10;
	localparam logic [7:0] SS_STEP_RST = 8'h10;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_S5 = 3'b001,
		ST_S0 = 3'b010,
		ST_S3 = 3'b100
	} drsfc_state_e;
	typedef struct packed {
		logic mem_en;
		logic term_en;
		logic sup_above_rise;
		logic sup_above_fall;
		logic overcurrent;
		logic overtemp;
		logic mem_fb_ok;
		logic mem_fb_over;
		logic mem_fb_under;
		logic term_fb_ok;
	} drsfc_sense_s;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} drsfc_wb_req_s;
	typedef struct packed {
		logic [2:0] state;
		logic supply_good;
		logic mem_inreg;
		logic term_inreg;
		logic soft_start;
		logic oc_latch;
		logic ot_latch;
		logic rail_fault;
	} drsfc_stat_s;
endpackage : drsfc_pkg

// ### sim/drsfc_psc_model.sv
// Behavioural model of the system power-state controller driving the two enables
`timescale 1ns/1ns
module drsfc_psc_model (
	input wire logic clk_i,
	output logic mem_en_o,
	output logic term_en_o
);
	initial begin
		mem_en_o = 1'b0;
		term_en_o = 1'b0;
	end
	// Enables move only just after an edge, like the real controller
	task automatic drive(input logic mem, input logic term);
		@(posedge clk_i);
		mem_en_o <= mem;
		term_en_o <= term;
	endtask : drive
	// Low long enough to pass the two-flop sampler, else the latch never sees it
	task automatic cycle_enable(input logic term);
		drive(1'b0, term);
		repeat (4) @(posedge clk_i);
		drive(1'b1, term);
	endtask : cycle_enable
endmodule : drsfc_psc_model

// ### sim/drsfc_top_tb_top.sv
// Self-checking bench for the rail state and fault controller
`timescale 1ns/1ns
module drsfc_top_tb_top import drsfc_pkg::*; ;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic mem_en, term_en;
	// Supply rise, supply fall, overcurrent, overtemp, fb ok, over, under, term ok
	logic [7:0] ana = 8'h00;
	drsfc_sense_s sense;
	drsfc_wb_req_s req = '0;
	logic [31:0] rdat, dat_w;
	logic ack_w, hs, ls, mrhiz, t_on, t_hiz, tcc, pok_oe, pok_o, sgood, minreg, tinreg;
	int err_total = 0;
	int samples_checked = 0;
	int overlap = 0;
	int ls_hi = 0;
	int per;
	assign sense = {mem_en, term_en, ana};
	always #50 clk_i = ~clk_i;
	drsfc_psc_model psc_inst (.clk_i(clk_i), .mem_en_o(mem_en), .term_en_o(term_en));
	drsfc_top drsfc_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .sense_i(sense),
		.wb_req_i(req), .wb_dat_o(dat_w), .wb_ack_o(ack_w), .high_side_gate_o(hs),
		.low_side_gate_o(ls), .memory_rail_hiz_o(mrhiz), .termination_on_o(t_on),
		.termination_hiz_o(t_hiz), .termination_cc_o(tcc), .power_ok_out_o(pok_o),
		.power_ok_out_oe_o(pok_oe), .supply_good_flag_o(sgood),
		.memory_rail_in_regulation_o(minreg), .termination_in_regulation_o(tinreg));
	always @(posedge clk_i) begin
		if (hs === 1'b1 && ls === 1'b1) overlap++;
		if (ls === 1'b1) ls_hi++;
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word
	task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:adr, dat:dat};
		// Only the watchdog ends this wait if ack never comes; ack is registered, so it shows on the second edge
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_w !== 1'b1);
		chk_word("bus ack latency", 32'h2, n);
		rdat = dat_w;
		req <= '0;
	endtask : wb_rw
	function automatic logic flag(input int k);
		return (k == 2) ? t_on : pok_oe;
	endfunction : flag
	task automatic wait_flag(input int k, input logic v);
		int n;
		for (n = 0; n < 3000 && flag(k) !== v; n++) @(posedge clk_i);
		chk_word("awaited flag", {31'h0, v}, {31'h0, flag(k)});
	endtask : wait_flag
	// Cycles between two high-side rises; 0 when the gate never rises
	task automatic period(output int p);
		logic prev;
		int n, r1;
		prev = hs;
		r1 = -1;
		p = 0;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (hs === 1'b1 && prev === 1'b0) begin
				if (r1 >= 0) begin
					p = n - r1;
					break;
				end
				r1 = n;
			end
			prev = hs;
		end
	endtask : period
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk_word("hs gate", 32'h0, {31'h0, hs});
		chk_word("mem rail hiz", 32'h1, {31'h0, mrhiz});
		chk_word("pok pull", 32'h1, {31'h0, pok_oe});
		chk_word("pok level", 32'h0, {31'h0, pok_o});
		wb_rw(1'b0, ADR_STAT, 32'h0);
		// Ramp reads as pending while held in S5, since it restarts from zero
		chk_word("stat reset", {22'h0, ST_S5, 7'h08}, rdat);
		wb_rw(1'b0, ADR_CTRL, 32'h0);
		chk_word("ctrl reset", {16'h0, SS_STEP_RST, 2'h0, DUTY_RST}, rdat);
		wb_rw(1'b1, ADR_CTRL, 32'hFFFF_FFFF);
		wb_rw(1'b0, ADR_CTRL, 32'h0);
		chk_word("ctrl write", 32'h0000_FF3F, rdat);
		wb_rw(1'b1, ADR_CTRL, {16'h0, SS_STEP_RST, 2'h0, DUTY_RST});
		wb_rw(1'b0, 8'h40, 32'h0);
		chk_word("unmapped read", 32'h0, rdat);
		$display("test registers done");
		ana <= 8'hC8;
		psc_inst.drive(1'b1, 1'b1);
		wait_flag(2, 1'b1);
		chk_word("term current mode", 32'h1, {31'h0, tcc});
		chk_word("mem inreg", 32'h1, {31'h0, minreg});
		chk_word("pok startup", 32'h1, {31'h0, pok_oe});
		ana <= 8'hC9;
		wait_flag(3, 1'b0);
		chk_word("term inreg", 32'h1, {31'h0, tinreg});
		chk_word("supply good", 32'h1, {31'h0, sgood});
		period(per);
		chk_word("S0 period", {26'h0, PER_S0}, per);
		wb_rw(1'b0, ADR_STAT, 32'h0);
		chk_word("stat S0", {23'h0, ST_S0, 3'b111}, {23'h0, rdat[9:4]});
		$display("test S0 done");
		psc_inst.drive(1'b1, 1'b0);
		wait_flag(3, 1'b1);
		repeat (8) @(posedge clk_i);
		ls_hi = 0;
		period(per);
		chk_word("S3 period", {26'h0, PER_S3}, per);
		chk_word("S3 low gate", 32'h0, ls_hi);
		chk_word("term hiz S3", 32'h1, {31'h0, t_hiz});
		$display("test S3 done");
		psc_inst.drive(1'b1, 1'b1);
		wait_flag(3, 1'b0);
		ana <= 8'hE9;
		repeat (60) @(posedge clk_i);
		ana <= 8'hC9;
		ls_hi = 0;
		period(per);
		chk_word("gates after oc", 32'h0, per + ls_hi);
		chk_word("term after oc", 32'h0, {31'h0, t_on});
		chk_word("pok after oc", 32'h1, {31'h0, pok_oe});
		psc_inst.cycle_enable(1'b1);
		repeat (6) @(posedge clk_i);
		wb_rw(1'b0, ADR_STAT, 32'h0);
		chk_word("soft start, oc", 32'h2, {30'h0, rdat[3:2]});
		wait_flag(3, 1'b0);
		$display("test overcurrent done");
		ana <= 8'hD9;
		repeat (10) @(posedge clk_i);
		ana <= 8'hC9;
		repeat (20) @(posedge clk_i);
		wb_rw(1'b0, ADR_STAT, 32'h0);
		chk_word("ot latch", 32'h1, {31'h0, rdat[1]});
		chk_word("pok after ot", 32'h1, {31'h0, pok_oe});
		psc_inst.cycle_enable(1'b1);
		wait_flag(3, 1'b0);
		$display("test overtemp done");
		ana <= 8'hCB;
		repeat (10) @(posedge clk_i);
		ana <= 8'hC9;
		repeat (20) @(posedge clk_i);
		wb_rw(1'b0, ADR_STAT, 32'h0);
		chk_word("rail fault latch", 32'h1, {31'h0, rdat[0]});
		chk_word("pok after rail fault", 32'h1, {31'h0, pok_oe});
		psc_inst.cycle_enable(1'b1);
		wait_flag(3, 1'b0);
		$display("test rail fault done");
		ana <= 8'h09;
		repeat (8) @(posedge clk_i);
		wb_rw(1'b0, ADR_STAT, 32'h0);
		chk_word("stat supply low", {25'h0, ST_S5, 1'b0}, {25'h0, rdat[9:6]});
		chk_word("term hiz S5", 32'h1, {31'h0, t_hiz});
		chk_word("gate overlap", 32'h0, overlap);
		$display("test supply loss done");
		final_report;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		$display("MISMATCH watchdog expected end seen hang");
		final_report;
	end
endmodule : drsfc_top_tb_top
